// >>> core/rgvb_defs.vh
// constants for the regulator control and bus-power sense block
`ifndef RGVB_DEFS_VH
`define RGVB_DEFS_VH
// ============================================================
// register byte addresses
`define RGVB_ADDR_CTRL 12'h000
`define RGVB_ADDR_IRQ_STAT 12'h004
`define RGVB_ADDR_IRQ_MASK 12'h008
`define RGVB_ADDR_SRC_EN 12'h00c
// ============================================================
// control register fields
`define RGVB_BIT_OFF 7
`define RGVB_BIT_LEVEL 6
`define RGVB_BIT_POL 5
`define RGVB_BIT_LOWPWR 4
`define RGVB_CTRL_RESET 8'h00
`define RGVB_CTRL_WMASK 8'hb0
// ============================================================
// interrupt status and mask fields
`define RGVB_IRQ_MATCH 0
`define RGVB_IRQ_RISE 1
`define RGVB_IRQ_FALL 2
`define RGVB_IRQ_W 3
// source enable register fields
`define RGVB_SRC_IRQ 0
`define RGVB_SRC_RST 1
`endif

// >>> core/rgvb_sync.v
// two-flop synchroniser for the bus-power sense pin
module rgvb_sync (
    input wire pclk,
    input wire presetn,
    input wire async_in,
    output wire sync_out
);
    reg meta_r;
    reg stable_r;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= 1'b0;
            stable_r <= 1'b0;
        end else begin
            meta_r <= async_in;
            stable_r <= meta_r;
        end
    end
    assign sync_out = stable_r;
endmodule // rgvb_sync

// >>> core/rgvb_apb_decode.v
// apb access qualification and address decode
module rgvb_apb_decode (
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    output wire wr_ctrl,
    output wire wr_stat,
    output wire wr_mask,
    output wire wr_src,
    output wire rd_any,
    output wire hit
);
`include "rgvb_defs.vh"
    wire acc;
    wire is_ctrl;
    wire is_stat;
    wire is_mask;
    wire is_src;
    assign acc = psel & penable;
    assign is_ctrl = (paddr == `RGVB_ADDR_CTRL);
    assign is_stat = (paddr == `RGVB_ADDR_IRQ_STAT);
    assign is_mask = (paddr == `RGVB_ADDR_IRQ_MASK);
    assign is_src = (paddr == `RGVB_ADDR_SRC_EN);
    assign hit = is_ctrl | is_stat | is_mask | is_src;
    assign wr_ctrl = acc & pwrite & is_ctrl;
    assign wr_stat = acc & pwrite & is_stat;
    assign wr_mask = acc & pwrite & is_mask;
    assign wr_src = acc & pwrite & is_src;
    assign rd_any = acc & ~pwrite;
endmodule // rgvb_apb_decode

// >>> core/rgvb_top.v
// regulator control and bus-power sense block with apb registers
`include "rgvb_defs.vh"

// Behaviour
// - after reset the regulator is switched on with no software action.
// - one control bit switches the regulator on or off, applied directly.
// - a mode bit selects normal or low-power (suspend) regulator operation.
// - a read-only status bit shows the present bus-power level.
// - when enabled, the bus-power interrupt rises while level equals polarity.
// - that interrupt is a pure level with no pending flag.
// - with the usb reset source on, a level match requests a system reset.
// - mode bit 1 means low-power, 0 means normal.
// - the four low control bits read zero and writes to them are dropped.
module rgvb_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire bus_power_in,
    output reg regulator_enable,
    output reg regulator_low_power,
    output reg bus_power_irq,
    output reg usb_reset_req,
    output reg irq
);

    // ============================================================
    // decode and synchroniser
    wire wr_ctrl;
    wire wr_stat;
    wire wr_mask;
    wire wr_src;
    wire rd_any;
    wire hit;
    wire level;

    rgvb_apb_decode u_dec (
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .wr_ctrl(wr_ctrl),
        .wr_stat(wr_stat),
        .wr_mask(wr_mask),
        .wr_src(wr_src),
        .rd_any(rd_any),
        .hit(hit)
    );

    rgvb_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(bus_power_in),
        .sync_out(level)
    );

    // ============================================================
    // registers
    reg off_r;
    reg pol_r;
    reg lowpwr_r;
    reg irq_en_r;
    reg rst_en_r;
    reg level_d_r;
    reg [`RGVB_IRQ_W-1:0] stat_r;
    reg [`RGVB_IRQ_W-1:0] mask_r;
    reg [`RGVB_IRQ_W-1:0] stat_nxt;
    reg [31:0] rdata_nxt;

    reg off_nxt;
    reg pol_nxt;
    reg lowpwr_nxt;
    reg irq_en_nxt;
    reg rst_en_nxt;
    reg [`RGVB_IRQ_W-1:0] mask_nxt;

    wire take;
    wire take_ctrl;
    wire take_stat;
    wire take_mask;
    wire take_src;
    wire match;
    wire [`RGVB_IRQ_W-1:0] events;

    // ============================================================
    // helpers
    // true when the synchronised level equals the selected polarity
    function level_matches;
        input lvl;
        input pol;
        begin
            level_matches = (lvl == pol);
        end
    endfunction

    // a written field replaces the old one only when the write is taken
    function pick_bit;
        input take_it;
        input new_bit;
        input old_bit;
        begin
            pick_bit = take_it ? new_bit : old_bit;
        end
    endfunction

    // ============================================================
    // write qualification
    // a write lands only on the completing edge, so a w1c clear
    // also wipes an event that was set on the first access edge
    assign take = pready;
    assign take_ctrl = wr_ctrl & take;
    assign take_stat = wr_stat & take;
    assign take_mask = wr_mask & take;
    assign take_src = wr_src & take;

    assign match = level_matches(level, pol_r);
    assign events = {level_d_r & ~level, ~level_d_r & level, match};

    // ============================================================
    // control register next values
    always @* begin
        off_nxt = pick_bit(take_ctrl, pwdata[`RGVB_BIT_OFF], off_r);
        pol_nxt = pick_bit(take_ctrl, pwdata[`RGVB_BIT_POL], pol_r);
        lowpwr_nxt = pick_bit(take_ctrl, pwdata[`RGVB_BIT_LOWPWR], lowpwr_r);
        irq_en_nxt = pick_bit(take_src, pwdata[`RGVB_SRC_IRQ], irq_en_r);
        rst_en_nxt = pick_bit(take_src, pwdata[`RGVB_SRC_RST], rst_en_r);
        mask_nxt = mask_r;
        if (take_mask) begin
            mask_nxt = pwdata[`RGVB_IRQ_W-1:0];
        end
    end

    // ============================================================
    // control register flops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            off_r <= 1'b0;
        end else begin
            off_r <= off_nxt;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pol_r <= 1'b0;
        end else begin
            pol_r <= pol_nxt;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lowpwr_r <= 1'b0;
        end else begin
            lowpwr_r <= lowpwr_nxt;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_r <= 1'b0;
        end else begin
            irq_en_r <= irq_en_nxt;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_en_r <= 1'b0;
        end else begin
            rst_en_r <= rst_en_nxt;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= {`RGVB_IRQ_W{1'b0}};
        end else begin
            mask_r <= mask_nxt;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_d_r <= 1'b0;
        end else begin
            level_d_r <= level;
        end
    end

    // ============================================================
    // sticky status: a set in the clearing cycle wins
    always @* begin
        stat_nxt = stat_r;
        if (take_stat) begin
            stat_nxt = stat_nxt & ~pwdata[`RGVB_IRQ_W-1:0];
        end
        stat_nxt = stat_nxt | events;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_r <= {`RGVB_IRQ_W{1'b0}};
        end else begin
            stat_r <= stat_nxt;
        end
    end

    // ============================================================
    // read data
    always @* begin
        rdata_nxt = 32'h00000000;
        case (paddr)
            `RGVB_ADDR_CTRL: begin
                rdata_nxt[`RGVB_BIT_OFF] = off_r;
                rdata_nxt[`RGVB_BIT_LEVEL] = level;
                rdata_nxt[`RGVB_BIT_POL] = pol_r;
                rdata_nxt[`RGVB_BIT_LOWPWR] = lowpwr_r;
                // low four bits stay zero
            end
            `RGVB_ADDR_IRQ_STAT: begin
                rdata_nxt[`RGVB_IRQ_W-1:0] = stat_r;
            end
            `RGVB_ADDR_IRQ_MASK: begin
                rdata_nxt[`RGVB_IRQ_W-1:0] = mask_r;
            end
            `RGVB_ADDR_SRC_EN: begin
                rdata_nxt[`RGVB_SRC_IRQ] = irq_en_r;
                rdata_nxt[`RGVB_SRC_RST] = rst_en_r;
            end
            default: begin
                rdata_nxt = 32'h00000000;
            end
        endcase
    end

    // ============================================================
    // registered outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else begin
            if (rd_any & ~pready) begin
                prdata <= rdata_nxt;
            end
        end
    end

    // one wait state: ready rises in the second access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel & penable & ~pready & ~hit;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            regulator_enable <= 1'b1;
        end else begin
            regulator_enable <= ~off_r;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            regulator_low_power <= 1'b0;
        end else begin
            regulator_low_power <= lowpwr_r;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_power_irq <= 1'b0;
        end else begin
            bus_power_irq <= irq_en_r & match;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            usb_reset_req <= 1'b0;
        end else begin
            usb_reset_req <= rst_en_r & match;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stat_r & mask_r);
        end
    end

endmodule // rgvb_top

// >>> bench/rgvb_top_properties.sv
// checker bound to the regulator control block ports
module rgvb_top_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic bus_power_in,
    input wire logic regulator_enable,
    input wire logic regulator_low_power,
    input wire logic bus_power_irq,
    input wire logic usb_reset_req
);
    timeunit 1ns;
    timeprecision 1ns;
    logic ac, rc, w0, w7, w5, w4, si, sr, pv;
    logic [3:0] st;
    assign ac = psel && penable && pready;
    assign rc = ac && !pwrite && paddr == 12'h000;
    assign w0 = ac && pwrite && paddr == 12'h000;
    // st counts quiet cycles: no completed access and no change on the sense pin
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {w7, w5, w4, si, sr, pv, st} <= 10'h000;
        end else begin
            if (w0)
                {w7, w5, w4} <= {pwdata[7], pwdata[5:4]};
            if (ac && pwrite && paddr == 12'h00c)
                {sr, si} <= pwdata[1:0];
            pv <= bus_power_in;
            st <= (ac || bus_power_in != pv) ? 4'h0 : st + {3'h0, st != 4'hf};
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_on_after_reset: assert property (
        $rose(presetn) |-> regulator_enable) else $error("regulator off");
    a_on_follows: assert property (
        !$past(w0) |-> regulator_enable == !w7) else $error("enable wrong");
    a_mode_follows: assert property (
        !$past(w0) |-> regulator_low_power == w4) else $error("mode wrong");
    a_level_read: assert property (
        rc && st > 4'h4 && bus_power_in == pv |-> prdata[6] == bus_power_in)
        else $error("level");
    a_rsvd_zero: assert property (
        rc |-> prdata[3:0] == 4'h0) else $error("reserved bits set");
    a_irq_match: assert property (
        st > 4'h4 && bus_power_in == pv |->
            bus_power_irq == (si && bus_power_in == w5))
        else $error("irq level wrong");
    a_rst_match: assert property (
        st > 4'h4 && bus_power_in == pv |->
            usb_reset_req == (sr && bus_power_in == w5))
        else $error("reset request wrong");
    a_sync_lag: assert property (
        $changed(bus_power_in) && st > 4'h4 |=> $stable(bus_power_irq))
        else $error("sense pin not synchronised");
endmodule // rgvb_top_chk

bind rgvb_top rgvb_top_chk chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .bus_power_in, .regulator_enable,
    .regulator_low_power, .bus_power_irq, .usb_reset_req);

// >>> bench/rgvb_host.sv
// bus-power source standing for the usb host at the sense pin
module rgvb_host #(
    parameter int DLY = 3
) (
    input wire logic pclk,
    input wire logic attach,
    output logic bus_power_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [DLY-1:0] d = '0;
    // power follows the cable event some cycles late
    always @(posedge pclk)
        d <= {d[DLY-2:0], attach};
    assign bus_power_in = d[DLY-1];
endmodule // rgvb_host

// >>> bench/rgvb_top_tb.sv
// testbench for the regulator control block
module rgvb_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, attach, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic bus_power_in, regulator_enable, regulator_low_power;
    logic bus_power_irq, usb_reset_req, irq;
    logic [32:0] regs, lines, q[$];
    logic [7:0] rnd = 8'h4b;
    int num_errors = 0, check_count = 0;
    assign regs = {31'h0, regulator_low_power, regulator_enable};
    assign lines = {31'h0, usb_reset_req, bus_power_irq};
    rgvb_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .bus_power_in, .regulator_enable,
        .regulator_low_power, .bus_power_irq, .usb_reset_req, .irq);
    rgvb_host host (.pclk, .attach, .bus_power_in);
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d, input logic [32:0] exp);
        int n;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        if (!wr) q.push_back(exp);
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            num_errors++;
            end_of_test();
        end
        {psel, penable} <= 2'h0;
    endtask
    always @(posedge pclk)
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk({pslverr, prdata}, q.pop_front());
    initial begin
        {psel, penable, pwrite, attach, presetn, paddr, pwdata} = 49'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        chk(regs, 33'h1);
        apb(1'b0, 12'h000, 32'h0, 33'h0);
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            // supply taken as self-powered here, so switching off is allowed
            apb(1'b1, 12'h000, {rnd, rnd, rnd, i[2], rnd[5], i[1:0], 4'h0},
                33'h0);
            apb(1'b0, 12'h000, 32'h0, {25'h0, i[2], 1'b0, i[1:0], 4'h0});
            chk(regs, {31'h0, i[0], ~i[2]});
        end
        apb(1'b1, 12'h00c, 32'h3, 33'h0);
        apb(1'b1, 12'h008, 32'h7, 33'h0);
        for (int p = 0; p < 2; p++)
            for (int v = 0; v < 2; v++) begin
                apb(1'b1, 12'h000, {26'h0, p[0], 5'h0}, 33'h0);
                repeat (8) @(posedge pclk);
                // move the pin while the bus is quiet
                attach <= v[0];
                repeat (8) @(posedge pclk);
                chk(lines, {31'h0, {2{v[0] == p[0]}}});
                apb(1'b0, 12'h000, 32'h0, {26'h0, v[0], p[0], 5'h0});
            end
        chk({32'h0, irq}, 33'h1);
        apb(1'b0, 12'h004, 32'h0, 33'h7);
        apb(1'b1, 12'h004, 32'h7, 33'h0);
        apb(1'b0, 12'h004, 32'h0, 33'h1);
        apb(1'b1, 12'h008, 32'h0, 33'h0);
        attach <= 1'b0;
        repeat (8) @(posedge pclk);
        chk({32'h0, irq}, 33'h0);
        apb(1'b1, 12'h004, 32'h7, 33'h0);
        apb(1'b1, 12'h008, 32'h7, 33'h0);
        repeat (2) @(posedge pclk);
        chk({32'h0, irq}, 33'h0);
        apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 12'h00c, 32'h0, 33'h0);
        attach <= 1'b1;
        repeat (8) @(posedge pclk);
        chk(lines, 33'h0);
        end_of_test();
    end
endmodule // rgvb_top_tb
